// File: core/mfm_monitor.sv
// Purpose: Motor drive fault supervision with AXI4-Lite registers
// Assumes: Inputs come from logic on clk_sys; one sample per PWM cycle
// Notes:   Controller reset request is registered: a one-cycle pulse on the script key, held high while a task stays stale with config bit 8 set
`timescale 1ns/1ps
// Overview of operation
// - Filter each PWM bus sample with new-sample weight 2^11/2^16.
// - Filtered bus voltage readable, refreshed on every sample.
// - Filtered voltage above over-voltage threshold sets flag bit 2.
// - Enable bit 2 passes over-voltage to active word and FAULT.
// - Filtered voltage below under-voltage threshold sets flag bit 3.
// - Enable bit 3 passes under-voltage to active word and FAULT.
// - Critical over-voltage stops motor, zero vector until cleared.
// - Critical over-voltage response ignores the enable mask.
// - At parking end, any phase current below threshold is phase loss.
// - Enable bit 8 passes phase loss to active word and FAULT.
// - Processing load above 95 percent raises execution fault.
// - Any task silent for 60 s raises execution fault.
// - Execution fault always sets flag bit 10.
// - Enable bit 10 passes execution fault to active word and FAULT.
// - Config bit 8 set: 60 s stale task resets the controller.
// - Writing 0xAE51 to script request word resets the controller.
// - Safety enabled: 1 s stale task enters failsafe mode.
// - Writing 1 to fault clear strobe releases the fault state.
module mfm_monitor
   import mfm_pkg::*;
#(
   parameter int LONG_CYC  = TASK_TIMEOUT_CYC,
   parameter int SHORT_CYC = SAFE_TIMEOUT_CYC
) (
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire mfm_sample_t       bus_sample,
   input  wire mfm_phase_t        phase,
   input  wire logic [6:0]        load_pct,
   input  wire logic [NUM_TASKS-1:0] task_beat,
   output logic                   motor_fault,
   output logic                   zero_vector,
   output logic                   failsafe,
   output logic                   ctrl_reset
);
   logic [15:0] filtered_bus_voltage, bus_overvoltage_threshold;
   logic [15:0] bus_undervoltage_threshold, critical_overvoltage_threshold;
   logic [15:0] phase_loss_threshold, fault_enable_mask;
   logic [15:0] system_task_configuration, fault_flag_word;
   logic [15:0] active_fault_word;
   logic        cmp_pending, pl_latch, crit;
   mfm_state_t  state, next_state;
   logic [15:0] next_filt;
   logic        next_cmp_pending, next_pl_latch;
   logic [15:0] next_flags;
   logic [NUM_TASKS-1:0] stale_long, stale_short;
   logic        exec_fault, any_long, any_short;
   logic        aw_held, w_held, next_aw_held, next_w_held;
   logic [7:0]  aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0]  w_strb, next_w_strb;
   logic        do_write, fault_clear_strobe, script_reset;
   logic        next_bvalid, next_rvalid, next_ctrl_reset;
   logic [1:0]  next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [15:0] next_ov, next_uv, next_cov, next_pl, next_en, next_cfg;
   logic        wmap;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_TASKS; gi++) begin : g_watch
         mfm_task_watch #(
            .LONG_CYC  (LONG_CYC),
            .SHORT_CYC (SHORT_CYC)
         ) u_watch (
            .clk_sys     (clk_sys),
            .nrst        (nrst),
            .heartbeat   (task_beat[gi]),
            .stale_long  (stale_long[gi]),
            .stale_short (stale_short[gi])
         );
      end
   endgenerate

   assign any_long   = |stale_long;
   assign any_short  = |stale_short;
   // Execution fault is a live condition, not latched
   assign exec_fault = (load_pct > 7'(LOAD_LIMIT_PCT))
                     | any_long;
   assign failsafe   = any_short & system_task_configuration[CFG_SAFETY];
   assign crit       = fault_flag_word[BIT_CRIT_OV];

   // Bus voltage filter and fault flag evaluation
   always_comb begin
      next_filt        = filtered_bus_voltage;
      next_cmp_pending = 1'b0;
      next_pl_latch    = pl_latch;
      next_flags       = fault_flag_word;
      if (bus_sample.valid) begin
         // y += (x - y) / 32, done in 17 bits to keep the sign
         next_filt = 16'(17'(filtered_bus_voltage)
                   + 17'($signed({1'b0, bus_sample.volt}
                   - {1'b0, filtered_bus_voltage}) >>> FILT_SHIFT));
         next_cmp_pending = 1'b1;
      end
      if (fault_clear_strobe) begin
         next_flags    = 16'h0000;
         next_pl_latch = 1'b0;
      end
      if (cmp_pending) begin
         if (filtered_bus_voltage > bus_overvoltage_threshold)
            next_flags[BIT_OV] = 1'b1;
         if (filtered_bus_voltage < bus_undervoltage_threshold)
            next_flags[BIT_UV] = 1'b1;
         if (filtered_bus_voltage > critical_overvoltage_threshold)
            next_flags[BIT_CRIT_OV] = 1'b1;
      end
      if (phase.parking_end &&
          (phase.ia < phase_loss_threshold ||
           phase.ib < phase_loss_threshold ||
           phase.ic < phase_loss_threshold)) begin
         next_pl_latch = 1'b1;
      end
      next_flags[BIT_PHASE_LOSS] = next_pl_latch;
      next_flags[BIT_EXEC]       = exec_fault;
   end

   // Critical bit bypasses the mask
   assign active_fault_word = (fault_flag_word & fault_enable_mask)
                            | (16'(crit) << BIT_CRIT_OV);

   always_comb begin
      next_state = state;
      unique case (state)
         // A clear holds RUN for one cycle so the fresh flags decide
         ST_RUN: begin
            if (crit && !fault_clear_strobe)
               next_state = ST_CRIT;
            else if (active_fault_word != 16'h0000 && !fault_clear_strobe)
               next_state = ST_FAULT;
         end
         ST_FAULT: begin
            if (fault_clear_strobe)
               next_state = ST_RUN;
            else if (crit)
               next_state = ST_CRIT;
         end
         ST_CRIT: begin
            if (fault_clear_strobe)
               next_state = ST_RUN;
         end
      endcase
   end

   assign motor_fault = (state != ST_RUN);
   assign zero_vector = (state == ST_CRIT);

   // AXI4-Lite slave: one write and one read outstanding
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
      end
   end

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      wmap = 1'b1;
      unique case (aw_addr)
         ADDR_OV_THR, ADDR_UV_THR, ADDR_COV_THR, ADDR_PL_THR,
         ADDR_ENABLE, ADDR_SYS_CFG, ADDR_CLEAR, ADDR_SCRIPT,
         ADDR_FILT_VOLT, ADDR_FLAGS, ADDR_ACTIVE, ADDR_STATUS: wmap = 1'b1;
         default: wmap = 1'b0;
      endcase
   end

   assign fault_clear_strobe = do_write && aw_addr == ADDR_CLEAR
                             && w_strb[0] && w_data[0];
   assign script_reset = do_write && aw_addr == ADDR_SCRIPT
                       && (&w_strb[1:0])
                       && w_data[15:0] == SCRIPT_RESET_KEY;

   always_comb begin
      next_ov  = bus_overvoltage_threshold;
      next_uv  = bus_undervoltage_threshold;
      next_cov = critical_overvoltage_threshold;
      next_pl  = phase_loss_threshold;
      next_en  = fault_enable_mask;
      next_cfg = system_task_configuration;
      if (do_write && (&w_strb[1:0])) begin
         unique case (aw_addr)
            ADDR_OV_THR:  next_ov  = w_data[15:0];
            ADDR_UV_THR:  next_uv  = w_data[15:0];
            ADDR_COV_THR: next_cov = w_data[15:0];
            ADDR_PL_THR:  next_pl  = w_data[15:0];
            ADDR_ENABLE:  next_en  = w_data[15:0];
            ADDR_SYS_CFG: next_cfg = w_data[15:0];
            default: ;
         endcase
      end
      next_bvalid = s_axi_bvalid && !s_axi_bready;
      next_bresp  = s_axi_bresp;
      if (do_write) begin
         next_bvalid = 1'b1;
         next_bresp  = wmap ? RESP_OKAY : RESP_SLVERR;
      end
      next_ctrl_reset = script_reset
                      | (any_long & system_task_configuration[CFG_TASK_RESET]);
   end

   always_comb begin
      next_rvalid = s_axi_rvalid && !s_axi_rready;
      next_rdata  = s_axi_rdata;
      next_rresp  = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         unique case (s_axi_araddr)
            ADDR_FILT_VOLT: next_rdata = {16'h0000, filtered_bus_voltage};
            ADDR_OV_THR:  next_rdata = {16'h0000, bus_overvoltage_threshold};
            ADDR_UV_THR:  next_rdata = {16'h0000, bus_undervoltage_threshold};
            ADDR_COV_THR: next_rdata =
                             {16'h0000, critical_overvoltage_threshold};
            ADDR_PL_THR:  next_rdata = {16'h0000, phase_loss_threshold};
            ADDR_FLAGS:   next_rdata = {16'h0000, fault_flag_word};
            ADDR_ENABLE:  next_rdata = {16'h0000, fault_enable_mask};
            ADDR_ACTIVE:  next_rdata = {16'h0000, active_fault_word};
            ADDR_SYS_CFG: next_rdata = {16'h0000, system_task_configuration};
            ADDR_CLEAR, ADDR_SCRIPT: next_rdata = 32'h0000_0000;
            ADDR_STATUS:  next_rdata = {26'h000_0000, any_short, any_long,
                                        failsafe, zero_vector, motor_fault,
                                        exec_fault};
            default: begin
               next_rdata = 32'h0000_0000;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         filtered_bus_voltage           <= 16'h0000;
         cmp_pending                    <= 1'b0;
         pl_latch                       <= 1'b0;
         fault_flag_word                <= 16'h0000;
         state                          <= ST_RUN;
         aw_held                        <= 1'b0;
         w_held                         <= 1'b0;
         aw_addr                        <= 8'h00;
         w_data                         <= 32'h0000_0000;
         w_strb                         <= 4'h0;
         bus_overvoltage_threshold      <= RST_OV_THR;
         bus_undervoltage_threshold     <= RST_UV_THR;
         critical_overvoltage_threshold <= RST_COV_THR;
         phase_loss_threshold           <= RST_PL_THR;
         fault_enable_mask              <= RST_ENABLE;
         system_task_configuration      <= RST_SYS_CFG;
         s_axi_bvalid                   <= 1'b0;
         s_axi_bresp                    <= RESP_OKAY;
         s_axi_rvalid                   <= 1'b0;
         s_axi_rdata                    <= 32'h0000_0000;
         s_axi_rresp                    <= RESP_OKAY;
         ctrl_reset                     <= 1'b0;
      end else begin
         filtered_bus_voltage           <= next_filt;
         cmp_pending                    <= next_cmp_pending;
         pl_latch                       <= next_pl_latch;
         fault_flag_word                <= next_flags;
         state                          <= next_state;
         aw_held                        <= next_aw_held;
         w_held                         <= next_w_held;
         aw_addr                        <= next_aw_addr;
         w_data                         <= next_w_data;
         w_strb                         <= next_w_strb;
         bus_overvoltage_threshold      <= next_ov;
         bus_undervoltage_threshold     <= next_uv;
         critical_overvoltage_threshold <= next_cov;
         phase_loss_threshold           <= next_pl;
         fault_enable_mask              <= next_en;
         system_task_configuration      <= next_cfg;
         s_axi_bvalid                   <= next_bvalid;
         s_axi_bresp                    <= next_bresp;
         s_axi_rvalid                   <= next_rvalid;
         s_axi_rdata                    <= next_rdata;
         s_axi_rresp                    <= next_rresp;
         ctrl_reset                     <= next_ctrl_reset;
      end
   end

   default clocking chk_cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   chk_ov_flag_set: assert property (
      cmp_pending && filtered_bus_voltage > bus_overvoltage_threshold
      |=> fault_flag_word[BIT_OV]) else $error("ov flag missed");
   chk_uv_flag_set: assert property (
      cmp_pending && filtered_bus_voltage < bus_undervoltage_threshold
      |=> fault_flag_word[BIT_UV]) else $error("uv flag missed");
   chk_crit_stops: assert property (
      crit && !fault_clear_strobe |=> zero_vector && motor_fault)
      else $error("critical not stopping");
   chk_crit_unmasked: assert property (
      crit && (fault_flag_word & fault_enable_mask) == 16'h0000
      && !fault_clear_strobe |=> motor_fault) else $error("critical masked");
   chk_mask_fault: assert property (
      state == ST_RUN && (fault_flag_word & fault_enable_mask) != 16'h0000
      && !fault_clear_strobe |=> motor_fault)
      else $error("enabled fault ignored");
   chk_masked_runs: assert property (
      state == ST_RUN && active_fault_word == 16'h0000 |=> !motor_fault)
      else $error("masked fault stopped motor");
   chk_exec_flag: assert property (
      load_pct > 7'(LOAD_LIMIT_PCT) |=> fault_flag_word[BIT_EXEC])
      else $error("exec flag missed");
   chk_script_reset: assert property (
      script_reset |=> ctrl_reset)
      else $error("script reset missed");
   chk_clear_release: assert property (
      fault_clear_strobe && motor_fault |=> state == ST_RUN)
      else $error("clear did not release");
   chk_filter_step: assert property (
      !bus_sample.valid |=> $stable(filtered_bus_voltage))
      else $error("filter moved without sample");
   cov_ov_fault: cover property (@(posedge clk_sys)
      state == ST_RUN ##1 state == ST_FAULT);
   cov_crit: cover property (@(posedge clk_sys) zero_vector);
   cov_clear: cover property (@(posedge clk_sys)
      fault_clear_strobe && motor_fault);
endmodule : mfm_monitor

// File: core/mfm_pkg.sv
// Purpose: Shared constants and types for the motor fault monitor
// Assumes: 20 MHz system clock, AXI4-Lite register access
// Notes:   Long liveness counts are overridable at the top level
package mfm_pkg;
   localparam int          CLK_HZ           = 20000000;
   localparam int          TASK_TIMEOUT_S   = 60;
   localparam int          SAFETY_TIMEOUT_S = 1;
   localparam int          TASK_TIMEOUT_CYC = CLK_HZ * TASK_TIMEOUT_S;
   localparam int          SAFE_TIMEOUT_CYC = CLK_HZ * SAFETY_TIMEOUT_S;
   localparam int          LOAD_LIMIT_PCT   = 95;
   localparam int          FILT_SHIFT       = 5;  // 2^11 / 2^16
   localparam int          NUM_TASKS        = 3;

   localparam logic [7:0]  ADDR_FILT_VOLT   = 8'h00;
   localparam logic [7:0]  ADDR_OV_THR      = 8'h04;
   localparam logic [7:0]  ADDR_UV_THR      = 8'h08;
   localparam logic [7:0]  ADDR_COV_THR     = 8'h0c;
   localparam logic [7:0]  ADDR_PL_THR      = 8'h10;
   localparam logic [7:0]  ADDR_FLAGS       = 8'h14;
   localparam logic [7:0]  ADDR_ENABLE      = 8'h18;
   localparam logic [7:0]  ADDR_ACTIVE      = 8'h1c;
   localparam logic [7:0]  ADDR_SYS_CFG     = 8'h20;
   localparam logic [7:0]  ADDR_CLEAR       = 8'h24;
   localparam logic [7:0]  ADDR_SCRIPT      = 8'h28;
   localparam logic [7:0]  ADDR_STATUS      = 8'h2c;

   localparam int          BIT_OV           = 2;
   localparam int          BIT_UV           = 3;
   localparam int          BIT_PHASE_LOSS   = 8;
   localparam int          BIT_EXEC         = 10;
   localparam int          BIT_CRIT_OV      = 11;
   localparam int          CFG_TASK_RESET   = 8;
   localparam int          CFG_SAFETY       = 0;
   localparam logic [15:0] SCRIPT_RESET_KEY = 16'hae51;

   localparam logic [15:0] RST_ENABLE       = 16'h0000;
   localparam logic [15:0] RST_OV_THR       = 16'hffff;
   localparam logic [15:0] RST_UV_THR       = 16'h0000;
   localparam logic [15:0] RST_COV_THR      = 16'hffff;
   localparam logic [15:0] RST_PL_THR       = 16'h0000;
   localparam logic [15:0] RST_SYS_CFG      = 16'h0000;
   localparam logic [1:0]  RESP_OKAY        = 2'b00;
   localparam logic [1:0]  RESP_SLVERR      = 2'b10;

   typedef struct packed {
      logic        valid;
      logic [15:0] volt;
   } mfm_sample_t;

   typedef struct packed {
      logic        parking_end;
      logic [15:0] ia;
      logic [15:0] ib;
      logic [15:0] ic;
   } mfm_phase_t;

   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_FAULT = 3'b010,
      ST_CRIT  = 3'b100
   } mfm_state_t;
endpackage : mfm_pkg

// File: core/mfm_task_watch.sv
// Purpose: Liveness counter for one background task
// Assumes: Heartbeat is a one-cycle pulse on the system clock
// Notes:   Both timeouts share one counter; it saturates
`timescale 1ns/1ps
module mfm_task_watch
   import mfm_pkg::*;
#(
   parameter int LONG_CYC  = TASK_TIMEOUT_CYC,
   parameter int SHORT_CYC = SAFE_TIMEOUT_CYC
) (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic heartbeat,
   output logic      stale_long,
   output logic      stale_short
);
   logic [31:0] count;
   logic [31:0] next_count;

   always_comb begin
      next_count = count;
      if (heartbeat) begin
         next_count = 32'h0000_0000;
      end else if (count < 32'(LONG_CYC)) begin
         next_count = count + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         count <= 32'h0000_0000;
      end else begin
         count <= next_count;
      end
   end

   assign stale_long  = (count >= 32'(LONG_CYC));
   assign stale_short = (count >= 32'(SHORT_CYC));
endmodule : mfm_task_watch

// File: test/mfm_host_model.sv
// Purpose: Far-side model giving PWM bus samples and task heartbeats
// Assumes: One sample every PWM_CYC cycles while run is high
// Notes:   Volt bus carries inverted data between samples
`timescale 1ns/1ps
module mfm_host_model
   import mfm_pkg::*;
#(
   parameter int PWM_CYC  = 8,
   parameter int BEAT_CYC = 16
) (
   input  wire logic                 clk_sys,
   input  wire logic                 run,
   input  wire logic [15:0]          volt,
   input  wire logic [NUM_TASKS-1:0] beats_on,
   output mfm_sample_t               bus_sample,
   output logic [NUM_TASKS-1:0]      task_beat
);
   int pc = 0;
   int bc = 0;
   always @(posedge clk_sys) begin
      pc <= (pc + 1) % PWM_CYC;
      bc <= (bc + 1) % BEAT_CYC;
      // Off-sample garbage exposes a filter that ignores valid
      bus_sample.valid <= run && pc == 0;
      bus_sample.volt <= (run && pc == 0) ? volt : ~volt;
      // A silent task simply stops beating
      task_beat <= (bc == 0) ? beats_on : '0;
   end
endmodule : mfm_host_model

// File: test/motor_fault_monitor_tb_top.sv
// Purpose: Self-checking bench for the motor fault monitor
// Assumes: Host model supplies samples and heartbeats
// Notes:   Liveness counts shortened to 200 and 50 cycles
`timescale 1ns/1ps
module motor_fault_monitor_tb_top
   import mfm_pkg::*;
;
   typedef struct packed {
      logic [15:0] ov, uv, cv, en, fl, act;
      logic        mf, zv;
   } mfm_row_t;
   logic        clk_sys = '0, nrst = '0, run = '0, s_axi_rready = '0;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
   logic        s_axi_arvalid = '0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   mfm_sample_t bus_sample;
   mfm_phase_t  phase = '0;
   logic [6:0]  load_pct = '0;
   logic [2:0]  task_beat, beats_on = 3'h7;
   logic        motor_fault, zero_vector, failsafe, ctrl_reset;
   logic [15:0] volt = 16'h8000;
   int          err_count = 0, num_checks = 0, scnt = 0, rcnt = 0, cyc = 0;
   mfm_row_t    rows[5] = '{
      '{16'h0100, 16'h0, 16'hffff, 16'h0, 16'h4, 16'h0, 1'h0, 1'h0},
      '{16'h0100, 16'h0, 16'hffff, 16'h4, 16'h4, 16'h4, 1'h1, 1'h0},
      '{16'hffff, 16'h1000, 16'hffff, 16'h0, 16'h8, 16'h0, 1'h0, 1'h0},
      '{16'hffff, 16'h1000, 16'hffff, 16'h8, 16'h8, 16'h8, 1'h1, 1'h0},
      '{16'hffff, 16'h0, 16'h0200, 16'h0, 16'h800, 16'h800, 1'h1, 1'h1}};

   always #25 clk_sys = ~clk_sys;
   mfm_monitor #(.LONG_CYC(200), .SHORT_CYC(50)) dut_u (
      .clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .bus_sample, .phase, .load_pct,
      .task_beat, .motor_fault, .zero_vector, .failsafe, .ctrl_reset);
   mfm_host_model host_u (.clk_sys, .run, .volt, .beats_on, .bus_sample,
      .task_beat);

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (bus_sample.valid === 1'h1)
         scnt <= scnt + 1;
      if (ctrl_reset === 1'h1)
         rcnt <= rcnt + 1;
      if (cyc == 30000) begin
         err_count++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask : chk

   // Handshakes are judged just before the edge that completes them
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic       ta, tw, tb;
      logic [1:0] tr;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(negedge clk_sys);
         ta = s_axi_awready;
         tw = s_axi_wready;
         tb = s_axi_bvalid;
         tr = s_axi_bresp;
         @(posedge clk_sys);
         if (ta === 1'h1)
            s_axi_awvalid <= 1'h0;
         if (tw === 1'h1)
            s_axi_wvalid <= 1'h0;
      end while (tb !== 1'h1);
      s_axi_bready <= 1'h0;
      // Idle edge so the next call never reassigns bready in one step
      @(posedge clk_sys);
      chk(32'(tr), 32'(RESP_OKAY));
   endtask : axw

   task automatic axr(input logic [7:0] a);
      logic ta, tv;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(negedge clk_sys);
         ta = s_axi_arready;
         tv = s_axi_rvalid;
         rd = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge clk_sys);
         if (ta === 1'h1)
            s_axi_arvalid <= 1'h0;
      end while (tv !== 1'h1);
      s_axi_rready <= 1'h0;
      @(posedge clk_sys);
   endtask : axr

   task automatic do_reset();
      nrst <= 1'h0;
      repeat (16) @(posedge clk_sys);
      nrst <= 1'h1;
      @(posedge clk_sys);
   endtask : do_reset

   initial begin
      logic [7:0]  ra[5] = '{ADDR_OV_THR, ADDR_UV_THR, ADDR_COV_THR,
                             ADDR_PL_THR, ADDR_ENABLE};
      logic [15:0] rv[5] = '{16'hffff, 16'h0, 16'hffff, 16'h0, 16'h0};
      int          b;
      do_reset();
      chk({motor_fault, zero_vector, failsafe, ctrl_reset}, 32'h0);
      foreach (ra[i]) begin
         axr(ra[i]);
         chk(rd, {16'h0, rv[i]});
      end
      foreach (rows[i]) begin
         do_reset();
         axw(ADDR_OV_THR, {16'h0, rows[i].ov});
         axw(ADDR_UV_THR, {16'h0, rows[i].uv});
         axw(ADDR_COV_THR, {16'h0, rows[i].cv});
         axw(ADDR_ENABLE, {16'h0, rows[i].en});
         b = scnt;
         run <= 1'h1;
         repeat (40) if (scnt < b + 1) @(posedge clk_sys);
         run <= 1'h0;
         repeat (6) @(posedge clk_sys);
         axr(ADDR_FILT_VOLT);
         chk(rd, 32'h0400);
         axr(ADDR_FLAGS);
         chk(rd, {16'h0, rows[i].fl});
         axr(ADDR_ACTIVE);
         chk(rd, {16'h0, rows[i].act});
         chk({motor_fault, zero_vector}, {rows[i].mf, rows[i].zv});
      end
      axw(ADDR_CLEAR, 32'h1);
      repeat (3) @(posedge clk_sys);
      chk({motor_fault, zero_vector}, 32'h0);
      load_pct <= 7'h60;
      repeat (4) @(posedge clk_sys);
      axr(ADDR_FLAGS);
      chk({rd[BIT_EXEC], motor_fault}, 32'h2);
      axw(ADDR_ENABLE, 32'h400);
      repeat (3) @(posedge clk_sys);
      chk(motor_fault, 32'h1);
      load_pct <= 7'h5f;
      repeat (4) @(posedge clk_sys);
      axr(ADDR_FLAGS);
      chk(rd[BIT_EXEC], 32'h0);
      axw(ADDR_CLEAR, 32'h1);
      axw(ADDR_PL_THR, 32'h10);
      axw(ADDR_ENABLE, 32'h100);
      // Equal to the threshold first, then one count below it
      for (int k = 0; k < 2; k++) begin
         phase <= '{1'h1, 16'h10, 16'h10, 16'h10 - 16'(k)};
         @(posedge clk_sys);
         phase.parking_end <= 1'h0;
         repeat (4) @(posedge clk_sys);
         chk(motor_fault, 32'(k));
      end
      axr(ADDR_FLAGS);
      chk(rd[BIT_PHASE_LOSS], 32'h1);
      axw(ADDR_CLEAR, 32'h1);
      b = rcnt;
      // Script resets come from an AXI write of the key; a wrong key goes first
      axw(ADDR_SCRIPT, 32'hae50);
      axw(ADDR_SCRIPT, {16'h0, SCRIPT_RESET_KEY});
      repeat (3) @(posedge clk_sys);
      chk(32'(rcnt - b), 32'h1);
      axw(ADDR_SYS_CFG, 32'h101);
      b = rcnt;
      beats_on <= 3'h3;
      repeat (25) @(posedge clk_sys);
      chk(failsafe, 32'h0);
      repeat (40) @(posedge clk_sys);
      chk(failsafe, 32'h1);
      repeat (200) @(posedge clk_sys);
      chk(32'(rcnt > b), 32'h1);
      axr(ADDR_FLAGS);
      chk(rd[BIT_EXEC], 32'h1);
      axr(ADDR_STATUS);
      chk(rd, 32'h39);
      beats_on <= 3'h7;
      axr(8'h30);
      chk(rsp, RESP_SLVERR);
      give_verdict();
   end
endmodule : motor_fault_monitor_tb_top
